// ---- src/aiw_pkg.sv ----
// Constants and types for the analog I/O and watchdog control block.
// Assumes a 10 MHz board clock and 32-bit word-aligned register accesses.
package aiw_pkg;
    // Register bus shape (512-byte window)
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS5    = 9'h014;
    localparam logic [ADDR_W-1:0] OFS_STATUS6    = 9'h018;
    localparam logic [ADDR_W-1:0] OFS_WD_CTRL    = 9'h04c;
    localparam logic [ADDR_W-1:0] OFS_WD_SERVICE = 9'h050;
    localparam logic [ADDR_W-1:0] OFS_DAC_FIRST  = 9'h060;
    localparam logic [ADDR_W-1:0] OFS_DAC_LAST   = 9'h07c;
    localparam logic [ADDR_W-1:0] OFS_ADC_DATA   = 9'h080;
    localparam logic [ADDR_W-1:0] OFS_ADC_START  = 9'h0a0;

    // Field positions
    localparam int WDC_BASE_BIT  = 0;
    localparam int WDC_EN_BIT    = 2;
    localparam int WDC_DACRT_BIT = 4;
    localparam int ST5_DONE_BIT  = 18;
    localparam int ST6_WDOG_BIT  = 22;

    // Codes written by software
    localparam logic [DATA_W-1:0] WD_SERVICE_CODE = 32'h0000005a;
    localparam logic [DATA_W-1:0] ADC_START_CODE  = 32'h00000001;

    // Converter widths and ADC commands
    localparam int DAC_W     = 13;
    localparam int ADC_W     = 14;
    localparam int ADC_CMD_W = 4;
    localparam int ADC_DEPTH = 4;
    localparam logic [ADC_CMD_W-1:0] ADC_CMD_PWRDN = 4'h8;
    localparam logic [ADC_CMD_W-1:0] ADC_CMD_RESET = 4'h0;

    // Reset values
    localparam logic WDC_BASE_RESET  = 1'b0;
    localparam logic WDC_EN_RESET    = 1'b0;
    localparam logic WDC_DACRT_RESET = 1'b0;

    // Watchdog intervals
    localparam int CLK_HZ      = 10_000_000;
    localparam int WD_SHORT_MS = 8;
    localparam int WD_LONG_MS  = 16;
    localparam int WD_SHORT_CYC = WD_SHORT_MS * (CLK_HZ / 1000);
    localparam int WD_LONG_CYC  = WD_LONG_MS * (CLK_HZ / 1000);
    localparam int WD_CNT_W     = 24;

    // Conversion sequence states
    typedef enum logic [1:0] {ADC_IDLE, ADC_COLLECT} aiw_adc_state_t;
endpackage

// ---- src/aiw_analog_io_watchdog_ctrl.sv ----
// Holds the ADC command, result store and done flag, DAC write strobes
// and the watchdog. Assumes the converters accept one-cycle strobes.
`timescale 1ns/1ps

module aiw_analog_io_watchdog_ctrl
    import aiw_pkg::*;
#(
    parameter int WD_SHORT_CYCLES = aiw_pkg::WD_SHORT_CYC, // 8 ms base
    parameter int WD_LONG_CYCLES  = aiw_pkg::WD_LONG_CYC   // 16 ms base
)
(
    input  wire logic                        mclk,        // Board clock
    input  wire logic                        rst_n,       // Sync reset, low
    input  wire logic                        ce,          // Clock enable
    input  wire logic [aiw_pkg::ADDR_W-1:0]  regAddr,     // Byte address
    input  wire logic                        regWrEn,     // Write strobe
    input  wire logic                        regRdEn,     // Read strobe
    input  wire logic [aiw_pkg::DATA_W-1:0]  regWrData,   // Write data
    output logic      [aiw_pkg::DATA_W-1:0]  regRdData,   // Read data
    output logic                             regRdValid,  // Read data valid
    output logic                             dacWrStb,    // DAC write cycle
    output logic      [2:0]                  dacChan,     // DAC channel
    output logic      [aiw_pkg::DAC_W-1:0]   dacCode,     // DAC code
    output logic                             adcCmdStb,   // ADC command write
    output logic      [aiw_pkg::ADC_CMD_W-1:0] adcCmd,    // ADC command
    output logic                             adcConvStb,  // Start conversion
    input  wire logic                        adcResValid, // Result strobe
    input  wire logic [aiw_pkg::ADC_W-1:0]   adcResData,  // Result word
    output logic                             wdOutN,      // Watchdog out, low
    output logic                             boardRst,    // Board reset pulse
    output logic                             outClear     // Clear outputs
);
    import aiw_pkg::*;

    aiw_adc_state_t                adcState_reg;
    logic [ADC_W-1:0]              resMem [ADC_DEPTH];
    logic [1:0]                    wrCnt_reg;
    logic [1:0]                    rdPtr_reg;
    logic                          doneN_reg;
    logic                          ctrlBase_reg;
    logic                          ctrlEn_reg;
    logic                          ctrlDacRt_reg;
    logic                          fired_reg;
    logic [WD_CNT_W-1:0]           wdCnt_reg;
    logic [WD_CNT_W-1:0]           wdLimit;
    logic [1:0]                    lastIdx;
    logic                          dacHit;
    logic                          svcHit;
    logic                          wdRestart;
    logic                          wdExpire;
    logic                          adcRd;
    logic                          adcComplete;
    logic                          startHit;

    // Address decode
    assign dacHit   = regWrEn && regAddr >= OFS_DAC_FIRST && regAddr <= OFS_DAC_LAST
                      && regAddr[1:0] == 2'b00;
    assign svcHit   = regWrEn && regAddr == OFS_WD_SERVICE && regWrData == WD_SERVICE_CODE;
    assign adcRd    = regRdEn && regAddr == OFS_ADC_DATA;
    assign lastIdx  = adcCmd[1:0];
    assign adcComplete = adcState_reg == ADC_COLLECT && adcResValid && wrCnt_reg == lastIdx;
    assign startHit = regWrEn && regAddr == OFS_ADC_START && regWrData == ADC_START_CODE
                      && adcState_reg == ADC_IDLE && adcCmd != ADC_CMD_PWRDN;

    assign wdRestart = svcHit || (dacHit && ctrlDacRt_reg);
    assign wdLimit  = ctrlBase_reg ? WD_CNT_W'(WD_LONG_CYCLES) : WD_CNT_W'(WD_SHORT_CYCLES);
    assign wdExpire = ctrlEn_reg && !fired_reg && !wdRestart && wdCnt_reg == wdLimit - 1'b1;

    // Watchdog control register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrlBase_reg  <= WDC_BASE_RESET;
            ctrlEn_reg    <= WDC_EN_RESET;
            ctrlDacRt_reg <= WDC_DACRT_RESET;
        end
        else if (ce && regWrEn && regAddr == OFS_WD_CTRL)
        begin
            ctrlBase_reg  <= regWrData[WDC_BASE_BIT];
            ctrlEn_reg    <= regWrData[WDC_EN_BIT];
            ctrlDacRt_reg <= regWrData[WDC_DACRT_BIT];
        end
    end

    // Watchdog counter
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            wdCnt_reg <= '0;
        else if (ce)
        begin
            if (!ctrlEn_reg || fired_reg || wdRestart || wdExpire)
                wdCnt_reg <= '0;
            else
                wdCnt_reg <= wdCnt_reg + 1'b1;
        end
    end

    // Timeout latch, held until watchdog disabled
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            fired_reg <= 1'b0;
            boardRst  <= 1'b0;
        end
        else if (ce)
        begin
            boardRst <= wdExpire;
            if (wdExpire)
                fired_reg <= 1'b1;
            else if (!ctrlEn_reg)
                fired_reg <= 1'b0;
        end
    end

    assign outClear = fired_reg;
    assign wdOutN   = !fired_reg;

    // DAC write path
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            dacWrStb <= 1'b0;
            dacChan  <= '0;
            dacCode  <= '0;
        end
        else if (ce)
        begin
            dacWrStb <= dacHit || wdExpire;
            if (wdExpire)
            begin
                dacChan <= '0;
                dacCode <= '0;
            end
            else if (dacHit)
            begin
                dacChan <= regAddr[4:2];
                dacCode <= regWrData[DAC_W-1:0];
            end
        end
    end

    // ADC command register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            adcCmd    <= ADC_CMD_RESET;
            adcCmdStb <= 1'b0;
        end
        else if (ce)
        begin
            adcCmdStb <= regWrEn && regAddr == OFS_ADC_DATA;
            if (regWrEn && regAddr == OFS_ADC_DATA)
                adcCmd <= regWrData[ADC_CMD_W-1:0];
        end
    end

    // Conversion sequence and result store
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            adcState_reg <= ADC_IDLE;
            wrCnt_reg    <= '0;
            adcConvStb   <= 1'b0;
        end
        else if (ce)
        begin
            adcConvStb <= startHit;
            unique case (adcState_reg)
                ADC_IDLE:
                    if (startHit)
                    begin
                        adcState_reg <= ADC_COLLECT;
                        wrCnt_reg    <= '0;
                    end
                ADC_COLLECT:
                    if (adcResValid)
                    begin
                        wrCnt_reg <= wrCnt_reg + 1'b1;
                        if (adcComplete)
                            adcState_reg <= ADC_IDLE;
                    end
            endcase
        end
    end

    for (genvar gi = 0; gi < ADC_DEPTH; gi++)
    begin : gResSlot
        always_ff @(posedge mclk)
        begin
            if (!rst_n)
                resMem[gi] <= '0;
            else if (ce && adcState_reg == ADC_COLLECT && adcResValid
                     && wrCnt_reg == 2'(gi))
                resMem[gi] <= adcResData;
        end
    end

    // Result read pointer
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rdPtr_reg <= '0;
        else if (ce)
        begin
            if (startHit)
                rdPtr_reg <= '0;
            else if (adcRd)
                rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end

    // Done flag, completion wins over read
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            doneN_reg <= 1'b1;
        else if (ce)
        begin
            if (adcComplete)
                doneN_reg <= 1'b0;
            else if (adcRd)
                doneN_reg <= 1'b1;
        end
    end

    // Registered read data
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            regRdData  <= '0;
            regRdValid <= 1'b0;
        end
        else if (ce)
        begin
            regRdValid <= regRdEn;
            regRdData  <= '0;
            if (regRdEn)
            begin
                unique case (regAddr)
                    OFS_ADC_DATA: regRdData[ADC_W-1:0] <= resMem[rdPtr_reg];
                    OFS_STATUS5:  regRdData[ST5_DONE_BIT] <= doneN_reg;
                    OFS_STATUS6:  regRdData[ST6_WDOG_BIT] <= wdOutN;
                    default:      regRdData <= '0;
                endcase
            end
        end
    end
    // Checks
    AST_DAC_RETRIG: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && dacHit && ctrlDacRt_reg |=> wdCnt_reg == '0)
        else $error("DAC write did not restart watchdog");
    AST_NO_DAC_RETRIG: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && dacHit && !ctrlDacRt_reg && !svcHit && ctrlEn_reg && !fired_reg && !wdExpire
        |=> wdCnt_reg == $past(wdCnt_reg) + 1'b1)
        else $error("DAC write restarted watchdog while retrigger off");
    AST_SVC_RESTART: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && svcHit |=> wdCnt_reg == '0)
        else $error("Service code did not restart watchdog");
    AST_WD_RUNS: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && ctrlEn_reg && !fired_reg && !wdRestart && !wdExpire
        |=> wdCnt_reg == $past(wdCnt_reg) + 1'b1)
        else $error("Watchdog counter did not advance");
    AST_DAC_STROBE: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && dacHit && !wdExpire |=> dacWrStb && dacChan == $past(regAddr[4:2])
        && dacCode == $past(regWrData[DAC_W-1:0]))
        else $error("DAC write cycle wrong");
    AST_DONE_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && adcComplete |=> !doneN_reg && adcState_reg == ADC_IDLE)
        else $error("Done flag not low after last result");
    AST_DONE_REARM: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && adcRd && !adcComplete |=> doneN_reg)
        else $error("Result read did not rearm done flag");
    AST_WD_TIMEOUT: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && wdExpire |=> boardRst && !wdOutN && outClear && dacCode == '0)
        else $error("Timeout effects missing");
    AST_WD_STATUS: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && regRdEn && regAddr == OFS_STATUS6 |=> regRdData[ST6_WDOG_BIT] == $past(wdOutN))
        else $error("Watchdog level misreported");
    AST_START_STB: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && startHit |=> adcConvStb && adcState_reg == ADC_COLLECT)
        else $error("Conversion did not start");
    COV_TIMEOUT: cover property (@(posedge mclk) disable iff (!rst_n) ce && wdExpire);
    COV_FOUR_CH: cover property (@(posedge mclk) disable iff (!rst_n)
        ce && adcComplete && lastIdx == 2'h3);
    COV_DAC_RT: cover property (@(posedge mclk) disable iff (!rst_n)
        ce && dacHit && ctrlDacRt_reg && ctrlEn_reg);
endmodule

// ---- tb/aiw_conv_model.sv ----
// Behavioural converter model: latches ADC commands, answers starts.
// Assumes one-cycle command and start strobes from the controller.
`timescale 1ns/1ps

module aiw_conv_model
    import aiw_pkg::*;
(
    input  wire logic                          mclk,        // Board clock
    input  wire logic                          rst_n,       // Sync reset, low
    input  wire logic                          adcCmdStb,   // Command write
    input  wire logic [aiw_pkg::ADC_CMD_W-1:0] adcCmd,      // Command value
    input  wire logic                          adcConvStb,  // Start strobe
    output logic                               adcResValid, // Result strobe
    output logic      [aiw_pkg::ADC_W-1:0]     adcResData   // Result word
);
    import aiw_pkg::*;

    logic [3:0] cmdReg;
    int         left;
    int         idx;
    int         gap;

    // Sequencer: results alternate fast and slow, data toggles when idle
    always @(posedge mclk)
    begin
        adcResValid <= 1'b0;
        adcResData  <= ~adcResData;
        if (!rst_n)
        begin
            cmdReg     <= 4'h0;
            left       <= 0;
            adcResData <= 14'h1555;
        end
        else
        begin
            if (adcCmdStb)
                cmdReg <= adcCmd;
            if (adcConvStb)
            begin
                left <= int'(cmdReg[1:0]) + 1;
                idx  <= 0;
                gap  <= 3;
            end
            else if (left > 0 && gap > 0)
                gap <= gap - 1;
            else if (left > 0)
            begin
                adcResValid <= 1'b1;
                adcResData  <= 14'(32'h2a0 + (int'(cmdReg[2]) * 4 + idx) * 273);
                idx         <= idx + 1;
                left        <= left - 1;
                gap         <= idx % 2 == 0 ? 0 : 2;
            end
        end
    end
endmodule

// ---- tb/aiw_analog_io_watchdog_ctrl_test.sv ----
// Self-checking bench for the analog I/O and watchdog controller.
// Assumes short watchdog limits of 20 and 40 cycles for simulation.
`timescale 1ns/1ps

module aiw_analog_io_watchdog_ctrl_test;
    import aiw_pkg::*;

    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [8:0]  regAddr = 9'h000;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData;
    logic        regRdValid, dacWrStb, adcCmdStb, adcConvStb, adcResValid;
    logic [2:0]  dacChan;
    logic [12:0] dacCode;
    logic [3:0]  adcCmd;
    logic [13:0] adcResData;
    logic        wdOutN, boardRst, outClear;
    int          err_total = 0;
    int          checks = 0;
    int          seed = 31;
    int          cyc = 0;
    int          rstCnt = 0;
    logic [13:0] expQ[$];

    aiw_analog_io_watchdog_ctrl #(.WD_SHORT_CYCLES(20), .WD_LONG_CYCLES(40))
    aiw_analog_io_watchdog_ctrl_i (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .dacWrStb(dacWrStb), .dacChan(dacChan), .dacCode(dacCode),
        .adcCmdStb(adcCmdStb), .adcCmd(adcCmd), .adcConvStb(adcConvStb),
        .adcResValid(adcResValid), .adcResData(adcResData), .wdOutN(wdOutN),
        .boardRst(boardRst), .outClear(outClear));

    aiw_conv_model aiw_conv_model_i (.mclk(mclk), .rst_n(rst_n),
        .adcCmdStb(adcCmdStb), .adcCmd(adcCmd), .adcConvStb(adcConvStb),
        .adcResValid(adcResValid), .adcResData(adcResData));

    // Clock and cycle bookkeeping
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (boardRst === 1'b1)
            rstCnt <= rstCnt + 1;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [8:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
        chk("regRdValid", 32'h1, {31'h0, regRdValid});
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Service, send a wrong code, then time the expiry and its effects
    task automatic wdtime(input int lim);
        int t0;
        logic [31:0] d;
        wr(OFS_WD_SERVICE, WD_SERVICE_CODE);
        t0 = cyc;
        wr(OFS_WD_SERVICE, 32'h5b);
        while (boardRst !== 1'b1 && cyc - t0 < 300)
            @(posedge mclk) #1;
        chk("expiry", 1, {31'h0, cyc - t0 >= lim - 1 && cyc - t0 <= lim + 2});
        @(posedge mclk) #1;
        chk("wdOutN", 0, {31'h0, wdOutN});
        chk("outClear", 1, {31'h0, outClear});
        chk("dacCode", 0, {19'h0, dacCode});
        rd(OFS_STATUS6, d);
        chk("wdog bit", 0, {31'h0, d[ST6_WDOG_BIT]});
        wr(OFS_WD_CTRL, 32'h0);
        @(posedge mclk) #1;
        chk("wdOutN off", 1, {31'h0, wdOutN});
    endtask

    initial
    begin
        logic [31:0] d;
        int n;
        int r0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_STATUS5, d);
        chk("done reset", 1, {31'h0, d[ST5_DONE_BIT]});
        chk("adcCmd reset", 0, {28'h0, adcCmd});
        rd(OFS_STATUS6, d);
        chk("wdog reset", 1, {31'h0, d[ST6_WDOG_BIT]});
        rd(9'h1fc, d);
        chk("unmapped", 0, d);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            d = i == 0 ? 32'h1000 : i == 1 ? 32'hffff_ffff : $random(seed);
            wr(OFS_DAC_FIRST + 9'(i * 4), d);
            chk("dacWrStb", 1, {31'h0, dacWrStb});
            chk("dacChan", i, {29'h0, dacChan});
            chk("dacCode", d[12:0], {19'h0, dacCode});
            @(posedge mclk) #1;
            chk("dacWrStb once", 0, {31'h0, dacWrStb});
        end
        $display("test dac done");
        for (int c = 0; c < 9; c++)
        begin
            wr(OFS_ADC_DATA, c);
            chk("adcCmd", c, {28'h0, adcCmd});
            if (c < 8)
                for (int k = 0; k <= c % 4; k++)
                    expQ.push_back(14'(32'h2a0 + ((c / 4) * 4 + k) * 273));
            if (c == 0)
                wr(OFS_ADC_START, 32'h2);
            wr(OFS_ADC_START, ADC_START_CODE);
            n = 0;
            d = 32'hffff_ffff;
            while (d[ST5_DONE_BIT] !== 1'b0 && n < 12)
            begin
                rd(OFS_STATUS5, d);
                n++;
            end
            chk("done low", c < 8 ? 0 : 1, {31'h0, d[ST5_DONE_BIT]});
            for (int k = 0; expQ.size() > 0; k++)
            begin
                rd(OFS_ADC_DATA, d);
                chk("result", expQ.pop_front(), {18'h0, d[13:0]});
                if (k == 0)
                begin
                    rd(OFS_STATUS5, d);
                    chk("done high", 1, {31'h0, d[ST5_DONE_BIT]});
                end
            end
        end
        $display("test adc done");
        wr(OFS_WD_CTRL, 32'h4);
        wdtime(20);
        wr(OFS_WD_CTRL, 32'h5);
        wdtime(40);
        for (int m = 0; m < 2; m++)
        begin
            r0 = rstCnt;
            wr(OFS_WD_CTRL, m == 0 ? 32'h14 : 32'h4);
            repeat (8)
            begin
                wr(OFS_DAC_FIRST + 9'h0c, $random(seed));
                repeat (8) @(posedge mclk);
            end
            chk("dac retrigger", m, {31'h0, rstCnt != r0});
            wr(OFS_WD_CTRL, 32'h0);
        end
        $display("test watchdog done");
        r0 = rstCnt;
        wr(OFS_WD_CTRL, 32'h4);
        @(posedge mclk);
        ce <= 1'b0;
        repeat (30) @(posedge mclk);
        wr(OFS_DAC_FIRST, 32'h0abc);
        chk("dacWrStb frozen", 0, {31'h0, dacWrStb});
        chk("frozen expiry", 0, {31'h0, rstCnt != r0});
        @(posedge mclk);
        ce <= 1'b1;
        repeat (30) @(posedge mclk);
        rst_n <= 1'b0;
        chk("ce expiry", 1, {31'h0, rstCnt != r0});
        chk("wdOutN tripped", 0, {31'h0, wdOutN});
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_STATUS6, d);
        chk("wdog mid reset", 1, {31'h0, d[ST6_WDOG_BIT]});
        chk("outClear reset", 0, {31'h0, outClear});
        chk("adcCmd mid reset", 0, {28'h0, adcCmd});
        $display("test freeze done");
        conclude();
    end
endmodule
